// File: verilog/ttc_pkg.sv
/*
  constants for the dual timer/event counter: register offsets,
  field positions and peripheral-cycle state timing.
  assumes a single 200 MHz clock; 12 clocks form one peripheral cycle.
*/
package ttc_pkg;
  // ==========================================================
  // register byte offsets (one aligned word each)
  localparam logic [4:0] OFS_MODE = 5'h00;
  localparam logic [4:0] OFS_CTRL = 5'h04;
  localparam logic [4:0] OFS_LOW0 = 5'h08;
  localparam logic [4:0] OFS_HIGH0 = 5'h0c;
  localparam logic [4:0] OFS_LOW1 = 5'h10;
  localparam logic [4:0] OFS_HIGH1 = 5'h14;
  localparam logic [4:0] OFS_AUX = 5'h18;
  // ==========================================================
  // mode register fields, channel 1 sits four bits higher
  localparam int MODE_LSB = 0;
  localparam int SRC_BIT = 2;
  localparam int GATE_BIT = 3;
  localparam int CH1_SHIFT = 4;
  // control register bits
  localparam int EXT_TYPE0 = 0;
  localparam int EXT_FLAG0 = 1;
  localparam int EXT_TYPE1 = 2;
  localparam int EXT_FLAG1 = 3;
  localparam int RUN0 = 4;
  localparam int OVF0 = 5;
  localparam int RUN1 = 6;
  localparam int OVF1 = 7;
  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  // ==========================================================
  // state timing: states s1p1..s6p2 are phases 0..11
  localparam logic [3:0] PHASES = 4'hc;
  localparam logic [3:0] PH_SAMPLE = 4'h9;
  localparam logic [3:0] PH_UPDATE = 4'h4;
  // operating modes
  localparam logic [1:0] M_13BIT = 2'h0;
  localparam logic [1:0] M_16BIT = 2'h1;
  localparam logic [1:0] M_RELOAD = 2'h2;
  localparam logic [1:0] M_SPLIT = 2'h3;
endpackage : ttc_pkg

// File: verilog/ttc_evt_if.sv
/*
  carries phase strobes to a pin conditioner and its count event back.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface ttc_evt_if;
  logic sample_tick; // input_sample_state strobe
  logic update_tick; // count_update_state strobe
  logic count_evt; // one counted falling edge
  modport core (output sample_tick, output update_tick, input count_evt);
  modport cond (input sample_tick, input update_tick, output count_evt);
endinterface : ttc_evt_if

// File: verilog/ttc_edge_cond.sv
/*
  conditions one external count pin: three-flop synchroniser,
  sampling once per peripheral cycle, falling-edge event.
  assumes strobes from the core on the same clock.
*/
`timescale 1ns/1ps
module ttc_edge_cond
  import ttc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // pin and core link
  input wire logic pin,
  ttc_evt_if.cond evt
);
  typedef struct packed
  {
    logic [2:0] sync; // synchroniser chain
    logic stable; // agreed pin level
    logic smp; // last input_sample_state sample
    logic pend; // edge seen, waiting for update state
  } ttc_cond_type;

  ttc_cond_type st_q, st_d;

  // ==========================================================
  // next state
  always_comb
  begin
    st_d = st_q;
    st_d.sync = {st_q.sync[1:0], pin};
    // a change counts once flops two and three agree
    if (st_q.sync[1] == st_q.sync[2])
    begin
      st_d.stable = st_q.sync[2];
    end
    if (evt.sample_tick)
    begin
      st_d.smp = st_q.stable;
      if (st_q.smp && !st_q.stable)
      begin
        st_d.pend = 1'b1;
      end
    end
    if (evt.update_tick)
    begin
      st_d.pend = 1'b0;
    end
  end

  // event may fire only in the update state
  assign evt.count_evt = evt.update_tick && st_q.pend;

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end
endmodule : ttc_edge_cond

// File: verilog/ttc_core.sv
/*
  dual 16-bit timer/event counter with avalon-mm register slave.
  assumes pins are asynchronous and an interrupt controller pulses
  the service acknowledges for one cycle.
*/
`timescale 1ns/1ps
module ttc_core
  import ttc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // external pins
  input wire logic count_pin_ch0,
  input wire logic count_pin_ch1,
  input wire logic ext_gate_pin_ch0_n,
  input wire logic ext_gate_pin_ch1_n,
  // serial_port_clock enable, same clock domain
  input wire logic serial_port_clock,
  // interrupt requests and service acknowledges
  output logic ovf_irq_ch0,
  output logic ovf_irq_ch1,
  output logic ext_irq_ch0,
  output logic ext_irq_ch1,
  input wire logic ovf_ack_ch0,
  input wire logic ovf_ack_ch1,
  input wire logic ext_ack_ch0,
  input wire logic ext_ack_ch1
);
  typedef struct packed
  {
    logic [7:0] mode; // counter_mode_register
    logic [7:0] ctrl; // counter_control_register
    logic [7:0] lo0, hi0, lo1, hi1; // count bytes
    logic [1:0] fast; // half-clock special mode per channel
    logic [3:0] phase; // state within peripheral cycle
    logic half; // divide-by-two enable
    logic [5:0] gsync; // two gate synchronisers, 3 flops each
    logic [1:0] gate_lvl; // agreed gate pin levels
    logic ack; // bus answer cycle
    logic [7:0] rdata; // captured read data
  } ttc_state_type;

  ttc_state_type st_q, st_d;
  ttc_evt_if evt0 ();
  ttc_evt_if evt1 ();
  logic en0, en1, tick0, tick1, hi_tick, ovf0_ev, ovf1_ev, wr_en;

  // ==========================================================
  // one channel step: returns {overflow, high, low}
  function automatic logic [16:0] ttc_step(input logic [1:0] m, input logic [7:0] lo,
                                           input logic [7:0] hi);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    unique case (m)
      M_13BIT:
      begin
        r[4:0] = lo[4:0] + 5'h01;
        if (lo[4:0] == 5'h1f)
        begin
          r[15:8] = hi + 8'h01;
          r[16] = (hi == 8'hff);
        end
      end
      M_16BIT:
      begin
        r[7:0] = lo + 8'h01;
        if (lo == 8'hff)
        begin
          r[15:8] = hi + 8'h01;
          r[16] = (hi == 8'hff);
        end
      end
      M_RELOAD:
      begin
        r[7:0] = (lo == 8'hff) ? hi : lo + 8'h01;
        r[16] = (lo == 8'hff);
      end
      M_SPLIT:
      begin
        r = {1'b0, hi, lo};
      end
    endcase
    return r;
  endfunction : ttc_step

  // ==========================================================
  // pin conditioners
  ttc_edge_cond u_cond0 (.clk(clk), .resetn(resetn), .pin(count_pin_ch0), .evt(evt0.cond));
  ttc_edge_cond u_cond1 (.clk(clk), .resetn(resetn), .pin(count_pin_ch1), .evt(evt1.cond));
  // sample to update spans the cycle boundary
  assign evt0.sample_tick = (st_q.phase == PH_SAMPLE);
  assign evt1.sample_tick = (st_q.phase == PH_SAMPLE);
  assign evt0.update_tick = (st_q.phase == PH_UPDATE);
  assign evt1.update_tick = (st_q.phase == PH_UPDATE);

  // ==========================================================
  // count enables and ticks
  // channel 0 fields from low nibble
  // gate pin high lets a gated channel run
  assign en0 = st_q.ctrl[RUN0] && (!st_q.mode[GATE_BIT] || st_q.gate_lvl[0]);
  // channel 1 fields from high nibble
  assign en1 = st_q.ctrl[RUN1] && (!st_q.mode[CH1_SHIFT + GATE_BIT] || st_q.gate_lvl[1]);
  assign tick0 = en0 && (st_q.fast[0] ? st_q.half :
                 st_q.mode[SRC_BIT] ? evt0.count_evt : evt0.update_tick);
  // mode 3 of channel 0 borrows the run bit, so channel 1 keeps ticking
  assign tick1 = en1 && (st_q.fast[1] ? st_q.half :
                 st_q.mode[CH1_SHIFT + SRC_BIT] ? evt1.count_evt : evt1.update_tick);
  // high byte counts serial clock under run bit 1
  assign hi_tick = (st_q.mode[1:0] == M_SPLIT) && st_q.ctrl[RUN1] && serial_port_clock;
  assign wr_en = write && st_q.ack;

  // ==========================================================
  // next state
  always_comb
  begin
    logic [16:0] s0, s1;
    logic [7:0] wd;
    s0 = '0;
    s1 = '0;
    wd = writedata[7:0];
    st_d = st_q;
    ovf0_ev = 1'b0;
    ovf1_ev = 1'b0;
    // state sequencer and half-rate divider
    st_d.phase = (st_q.phase == PHASES - 4'h1) ? 4'h0 : st_q.phase + 4'h1;
    st_d.half = !st_q.half;
    // gate synchronisers: first flop of each chain reads its pin, each later flop the flop before it
    st_d.gsync = {st_q.gsync[4:3], ext_gate_pin_ch1_n, st_q.gsync[1:0], ext_gate_pin_ch0_n};
    if (st_q.gsync[1] == st_q.gsync[2])
    begin
      st_d.gate_lvl[0] = st_q.gsync[2];
    end
    if (st_q.gsync[4] == st_q.gsync[5])
    begin
      st_d.gate_lvl[1] = st_q.gsync[5];
    end
    if (tick0)
    begin
      if (st_q.mode[1:0] == M_SPLIT)
      begin
        // low byte as plain 8-bit channel 0
        st_d.lo0 = st_q.lo0 + 8'h01;
        ovf0_ev = (st_q.lo0 == 8'hff);
      end
      else
      begin
        s0 = ttc_step(st_q.mode[1:0], st_q.lo0, st_q.hi0);
        {ovf0_ev, st_d.hi0, st_d.lo0} = s0;
      end
    end
    if (hi_tick)
    begin
      st_d.hi0 = st_q.hi0 + 8'h01;
      ovf1_ev = (st_q.hi0 == 8'hff);
    end
    if (tick1)
    begin
      s1 = ttc_step(st_q.mode[CH1_SHIFT +: 2], st_q.lo1, st_q.hi1);
      {st_d.hi1, st_d.lo1} = s1[15:0];
      // channel 1 loses its flag while channel 0 splits
      if (st_q.mode[1:0] != M_SPLIT)
      begin
        ovf1_ev = s1[16];
      end
    end
    // bus answer one cycle after the request
    st_d.ack = (read || write) && !st_q.ack;
    if ((read || write) && !st_q.ack)
    begin
      unique case (address)
        OFS_MODE: st_d.rdata = st_q.mode;
        OFS_CTRL: st_d.rdata = st_q.ctrl;
        OFS_LOW0: st_d.rdata = st_q.lo0;
        OFS_HIGH0: st_d.rdata = st_q.hi0;
        OFS_LOW1: st_d.rdata = st_q.lo1;
        OFS_HIGH1: st_d.rdata = st_q.hi1;
        OFS_AUX: st_d.rdata = {6'h00, st_q.fast};
        default: st_d.rdata = 8'h00;
      endcase
    end
    // software writes, held stable by caller
    if (wr_en)
    begin
      unique case (address)
        OFS_MODE: st_d.mode = wd;
        OFS_CTRL: st_d.ctrl = wd;
        OFS_LOW0: st_d.lo0 = wd;
        OFS_HIGH0: st_d.hi0 = wd;
        OFS_LOW1: st_d.lo1 = wd;
        OFS_HIGH1: st_d.hi1 = wd;
        OFS_AUX: st_d.fast = wd[1:0];
        default: st_d.fast = st_d.fast;
      endcase
    end
    if (ovf_ack_ch0)
    begin
      st_d.ctrl[OVF0] = 1'b0;
    end
    if (ovf_ack_ch1)
    begin
      st_d.ctrl[OVF1] = 1'b0;
    end
    // edge-type external flags: service clears
    if (ext_ack_ch0 && st_q.ctrl[EXT_TYPE0])
    begin
      st_d.ctrl[EXT_FLAG0] = 1'b0;
    end
    if (ext_ack_ch1 && st_q.ctrl[EXT_TYPE1])
    begin
      st_d.ctrl[EXT_FLAG1] = 1'b0;
    end
    // external flags: falling edge or low level; set beats any clear
    if (st_q.ctrl[EXT_TYPE0] ? (st_q.gate_lvl[0] && !st_d.gate_lvl[0]) : !st_q.gate_lvl[0])
    begin
      st_d.ctrl[EXT_FLAG0] = 1'b1;
    end
    else if (!st_q.ctrl[EXT_TYPE0])
    begin
      st_d.ctrl[EXT_FLAG0] = 1'b0;
    end
    if (st_q.ctrl[EXT_TYPE1] ? (st_q.gate_lvl[1] && !st_d.gate_lvl[1]) : !st_q.gate_lvl[1])
    begin
      st_d.ctrl[EXT_FLAG1] = 1'b1;
    end
    else if (!st_q.ctrl[EXT_TYPE1])
    begin
      st_d.ctrl[EXT_FLAG1] = 1'b0;
    end
    // rollover sets flag, set beats clear
    if (ovf0_ev)
    begin
      st_d.ctrl[OVF0] = 1'b1;
    end
    if (ovf1_ev)
    begin
      st_d.ctrl[OVF1] = 1'b1;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= '0;
      st_q.mode <= MODE_RST;
      st_q.ctrl <= CTRL_RST;
      st_q.gsync <= 6'h3f;
      st_q.gate_lvl <= 2'h3;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // outputs
  assign waitrequest = (read || write) && !st_q.ack;
  assign readdata = {24'h000000, st_q.rdata};
  assign ovf_irq_ch0 = st_q.ctrl[OVF0];
  assign ovf_irq_ch1 = st_q.ctrl[OVF1];
  assign ext_irq_ch0 = st_q.ctrl[EXT_FLAG0];
  assign ext_irq_ch1 = st_q.ctrl[EXT_FLAG1];

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_m1_carry;
    tick0 && st_q.mode[1:0] == M_16BIT && st_q.lo0 == 8'hff && st_q.hi0 != 8'hff && !wr_en;
  endsequence
  sequence s_m2_wrap;
    tick0 && st_q.mode[1:0] == M_RELOAD && st_q.lo0 == 8'hff && !wr_en;
  endsequence
  cascade_carry_a: assert property (s_m1_carry |=> st_q.hi0 == $past(st_q.hi0) + 8'h01)
    else $error("high byte missed carry");
  run_keep_a: assert property (wr_en && address == OFS_CTRL && !st_q.ctrl[RUN0] && !hi_tick
    |=> st_q.lo0 == $past(st_q.lo0) && st_q.hi0 == $past(st_q.hi0))
    else $error("start changed count");
  // timer ticks once per peripheral cycle
  timer_phase_a: assert property (tick0 && !st_q.fast[0] && !st_q.mode[SRC_BIT]
    |-> st_q.phase == PH_UPDATE ##1 (!tick0) [*8])
    else $error("timer ticked off phase");
  half_rate_a: assert property (en0 && st_q.fast[0] && $past(en0 && st_q.fast[0])
    |-> tick0 != $past(tick0))
    else $error("half rate broken");
  // gated channel holds its low byte while the pin is low
  gate_block_a: assert property (st_q.mode[GATE_BIT] && !st_q.gate_lvl[0] && !wr_en
    |=> $stable(st_q.lo0))
    else $error("gated channel counted");
  ovf_flag_a: assert property (ovf0_ev |=> ovf_irq_ch0)
    else $error("overflow flag not set");
  ack_clear_a: assert property (ovf_ack_ch0 && !ovf0_ev |=> !ovf_irq_ch0)
    else $error("service left flag set");
  reload_a: assert property (s_m2_wrap |=> st_q.lo0 == $past(st_q.hi0) && ovf_irq_ch0)
    else $error("reload wrong");
  // channel 1 holds in mode 3
  hold_ch1_a: assert property (st_q.mode[CH1_SHIFT +: 2] == M_SPLIT && !wr_en
    |=> $stable(st_q.lo1) && $stable(st_q.hi1))
    else $error("channel 1 moved in halt");
  // a counted edge lands only in the update state
  edge_update_a: assert property (st_q.mode[SRC_BIT] && !st_q.fast[0] && st_q.phase != PH_UPDATE
    && !wr_en |=> $stable(st_q.lo0))
    else $error("edge count off update state");
endmodule : ttc_core

// File: tb/ttc_pin_model.sv
/*
  model of the external count and gate pins of channel 0.
  assumes the bench calls its tasks just after a rising clk edge
  and seeds the random generator beforehand.
*/
`timescale 1ns/1ps
module ttc_pin_model
(
  // clock
  input wire logic clk,
  // pins toward the block
  output logic count_pin,
  output logic gate_pin_n
);
  // ==========================================================
  // idle high on both pins: no edge counted, gate not asserted
  initial
  begin
    count_pin = 1'b1;
    gate_pin_n = 1'b1;
  end
  // ==========================================================
  // n falling edges, each level held a random 12..20 cycles
  task automatic falls(input int n);
    int h;
    for (int i = 0; i < n; i++)
    begin
      h = 12 + $urandom_range(8, 0);
      count_pin <= 1'b0;
      repeat (h) @(posedge clk);
      count_pin <= 1'b1;
      repeat (h) @(posedge clk);
    end
  endtask : falls
  // gate level, then time for the synchroniser to settle
  task automatic gate(input logic v);
    gate_pin_n <= v;
    repeat (4) @(posedge clk);
  endtask : gate
endmodule : ttc_pin_model

// File: tb/ttc_core_bench.sv
/*
  self-checking bench for the dual timer/event counter core.
  assumes the avalon slave answers within a few cycles and that
  one phase-4 tick falls in every 12 consecutive clocks.
*/
`timescale 1ns/1ps
module ttc_core_bench
  import ttc_pkg::*;
();
  // clock, reset and bus
  logic clk;
  logic resetn;
  logic [4:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  // pins and interrupt side
  logic count_pin_ch0;
  logic gate_n_ch0;
  logic serial_port_clock;
  logic ovf_ack_ch0;
  logic ovf_irq_ch0;
  logic ovf_irq_ch1;
  logic ovf_ack_ch1;
  logic ext_ack_ch0;
  logic ext_irq_ch0;
  logic ext_irq_ch1;
  // expected read data, oldest first
  logic [7:0] exp_q[$];
  string nm_q[$];
  int n_mismatch;
  int comparisons;
  int cyc;
  int n;
  ttc_core ttc_core_inst (.clk(clk), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .count_pin_ch0(count_pin_ch0), .count_pin_ch1(1'b1), .ext_gate_pin_ch0_n(gate_n_ch0),
    .ext_gate_pin_ch1_n(1'b1), .serial_port_clock(serial_port_clock),
    .ovf_irq_ch0(ovf_irq_ch0), .ovf_irq_ch1(ovf_irq_ch1), .ext_irq_ch0(ext_irq_ch0),
    .ext_irq_ch1(ext_irq_ch1), .ovf_ack_ch0(ovf_ack_ch0), .ovf_ack_ch1(ovf_ack_ch1),
    .ext_ack_ch0(ext_ack_ch0), .ext_ack_ch1(1'b0));
  ttc_pin_model pin_ch0 (.clk(clk), .count_pin(count_pin_ch0), .gate_pin_n(gate_n_ch0));
  // ==========================================================
  // compare and close
  function automatic void cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endfunction : cmp
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // ==========================================================
  // clock, timeout and read monitor
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // all tests take at most about 800 cycles; leave ample margin
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  // readdata stands at the edge where waitrequest is low
  always @(posedge clk)
    if (read === 1'b1 && waitrequest === 1'b0)
      cmp(nm_q.pop_front(), {24'h0, exp_q.pop_front()}, readdata);
  // ==========================================================
  // bus tasks: enter just after an edge, release after the answer
  task automatic wait_ans();
    @(posedge clk);
    while (waitrequest !== 1'b0)
      @(posedge clk);
  endtask : wait_ans
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    address <= a;
    writedata <= {24'h0, d};
    write <= 1'b1;
    wait_ans();
    write <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input string nm);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    address <= a;
    read <= 1'b1;
    wait_ans();
    read <= 1'b0;
    @(posedge clk);
  endtask : rd
  // run for exactly t ticks: both writes land at the same phase offset
  task automatic run_for(input logic [7:0] on, input int t, input logic [7:0] off, input logic spc,
    input logic [1:0] irq);
    wr(OFS_CTRL, on);
    for (int i = 0; i < 12 * t - 3; i++)
    begin
      serial_port_clock <= spc && (i == 4 || i == 6);
      @(posedge clk);
    end
    serial_port_clock <= 1'b0;
    // overflow flags as seen while still running, before the stop write
    cmp("ovf_irq", {30'h0, irq}, {30'h0, ovf_irq_ch1, ovf_irq_ch0});
    wr(OFS_CTRL, off);
  endtask : run_for
  // presets are written only while the channel is stopped
  task automatic setup(input logic [7:0] m, input logic [4:0] lo_a, input logic [7:0] lo,
    input logic [7:0] hi);
    wr(OFS_MODE, m);
    wr(lo_a, lo);
    wr(lo_a + 5'h04, hi);
  endtask : setup
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask : done
  // ==========================================================
  // main sequence
  initial
  begin
    resetn = 1'b0;
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    serial_port_clock = 1'b0;
    ovf_ack_ch0 = 1'b0;
    ovf_ack_ch1 = 1'b0;
    ext_ack_ch0 = 1'b0;
    void'($urandom(32'h6ded));
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    // reset values, unmapped word and mode register read-back
    for (int a = 0; a < 8; a++)
      rd(5'(a * 4), 8'h00, "reset");
    cmp("ext_irq_ch1", 32'h0, {31'h0, ext_irq_ch1});
    wr(5'h1c, 8'hff);
    rd(5'h1c, 8'h00, "unmapped");
    wr(OFS_MODE, 8'ha5);
    rd(OFS_MODE, 8'ha5, "mode");
    done("registers");
    // mode 1 cascade through ffff, preset kept at start
    setup(8'h01, OFS_LOW0, 8'hfe, 8'hff);
    run_for(8'h10, 3, 8'h20, 1'b0, 2'b01);
    rd(OFS_LOW0, 8'h01, "low0");
    rd(OFS_HIGH0, 8'h00, "high0");
    rd(OFS_CTRL, 8'h20, "ctrl");
    cmp("ovf_irq_ch0", 32'h1, {31'h0, ovf_irq_ch0});
    wr(OFS_CTRL, 8'h00);
    done("cascade");
    // mode 0 prescaler of five bits
    setup(8'h00, OFS_LOW0, 8'hfe, 8'h07);
    run_for(8'h10, 3, 8'h00, 1'b0, 2'b00);
    rd(OFS_LOW0, 8'he1, "low0");
    rd(OFS_HIGH0, 8'h08, "high0");
    done("prescaler");
    // half-rate special mode: 36 running edges give 18 counts
    setup(8'h01, OFS_LOW0, 8'h00, 8'h00);
    wr(OFS_AUX, 8'h01);
    run_for(8'h10, 3, 8'h00, 1'b0, 2'b00);
    rd(OFS_LOW0, 8'h12, "low0");
    wr(OFS_AUX, 8'h00);
    done("half rate");
    // mode 2, reload value changed while running
    setup(8'h02, OFS_LOW0, 8'hfe, 8'h00);
    wr(OFS_CTRL, 8'h10);
    wr(OFS_HIGH0, 8'h80);
    repeat (30) @(posedge clk);
    wr(OFS_CTRL, 8'h20);
    rd(OFS_LOW0, 8'h81, "low0");
    rd(OFS_HIGH0, 8'h80, "high0");
    rd(OFS_CTRL, 8'h20, "ctrl");
    ovf_ack_ch0 <= 1'b1;
    @(posedge clk);
    ovf_ack_ch0 <= 1'b0;
    @(posedge clk);
    cmp("ovf_irq_ch0", 32'h0, {31'h0, ovf_irq_ch0});
    rd(OFS_CTRL, 8'h00, "ctrl");
    done("reload");
    // event counting on the pin, random number of falls
    setup(8'h05, OFS_LOW0, 8'h00, 8'h00);
    wr(OFS_CTRL, 8'h10);
    n = 1 + $urandom_range(5, 0);
    pin_ch0.falls(n);
    repeat (36) @(posedge clk);
    wr(OFS_CTRL, 8'h00);
    rd(OFS_LOW0, 8'(n), "low0");
    done("events");
    // gate pin asserted stops counting, released lets it run
    setup(8'h09, OFS_LOW0, 8'h00, 8'h00);
    pin_ch0.gate(1'b0);
    run_for(8'h10, 2, 8'h00, 1'b0, 2'b00);
    rd(OFS_LOW0, 8'h00, "low0");
    cmp("ext_irq_ch0", 32'h1, {31'h0, ext_irq_ch0});
    pin_ch0.gate(1'b1);
    run_for(8'h10, 2, 8'h00, 1'b0, 2'b00);
    rd(OFS_LOW0, 8'h02, "low0");
    // edge-type flag: set by a gate fall, cleared by its service pulse
    wr(OFS_CTRL, 8'h01);
    pin_ch0.gate(1'b0);
    repeat (2) @(posedge clk);
    cmp("ext_irq_ch0", 32'h1, {31'h0, ext_irq_ch0});
    ext_ack_ch0 <= 1'b1;
    @(posedge clk);
    ext_ack_ch0 <= 1'b0;
    @(posedge clk);
    cmp("ext_irq_ch0", 32'h0, {31'h0, ext_irq_ch0});
    pin_ch0.gate(1'b1);
    done("gate");
    // channel 0 split: low on run0, high on serial clock and ch1 bits
    setup(8'h03, OFS_LOW0, 8'h00, 8'hfe);
    run_for(8'h50, 2, 8'h80, 1'b1, 2'b10);
    rd(OFS_LOW0, 8'h02, "low0");
    rd(OFS_HIGH0, 8'h00, "high0");
    rd(OFS_CTRL, 8'h80, "ctrl");
    cmp("ovf_irq_ch1", 32'h1, {31'h0, ovf_irq_ch1});
    ovf_ack_ch1 <= 1'b1;
    @(posedge clk);
    ovf_ack_ch1 <= 1'b0;
    @(posedge clk);
    cmp("ovf_irq_ch1", 32'h0, {31'h0, ovf_irq_ch1});
    wr(OFS_CTRL, 8'h00);
    done("split");
    // channel 1 counts on run1, then mode 3 holds it
    setup(8'h10, OFS_LOW1, 8'h05, 8'h00);
    run_for(8'h40, 2, 8'h00, 1'b0, 2'b00);
    rd(OFS_LOW1, 8'h07, "low1");
    wr(OFS_MODE, 8'h30);
    run_for(8'h40, 3, 8'h00, 1'b0, 2'b00);
    rd(OFS_LOW1, 8'h07, "low1");
    rd(OFS_HIGH1, 8'h00, "high1");
    done("hold");
    repeat (2) @(posedge clk);
    wrap_up();
  end
endmodule : ttc_core_bench
